/* hw/dwt_timer.sv */
// Dead-time waveform timer with AXI4-Lite registers, event inputs and blanking.
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/100ps
module dwt_timer
	import dwt_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic event_in_a,
	input wire logic event_in_b,
	output logic wave_out_a,
	output logic wave_out_b,
	output logic capture_a,
	output logic capture_b,
	output logic delay_event_out
);
	// Register state
	logic aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [7:0] aw_addr_q, aw_addr_d;
	logic [31:0] w_data_q, w_data_d;
	logic [3:0] w_strb_q, w_strb_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic enable_q, enable_d;
	dwt_scheme_e wave_scheme_sel_q, wave_scheme_sel_d;
	dwt_cmp_s cmp_q, cmp_d;
	dwt_evcfg_s ev_a_q, ev_a_d, ev_b_q, ev_b_d;
	dwt_delay_s dly_q, dly_d;
	logic stop_eoc_q, stop_eoc_d;
	// Counter domain state
	logic run_q, run_d, down_q, down_d;
	logic [DWT_CW-1:0] cnt_q, cnt_d;
	dwt_state_e state_q, state_d;
	logic out_a_q, out_a_d, out_b_q, out_b_d;
	logic [1:0] pipe_a_q, pipe_a_d, pipe_b_q, pipe_b_d;
	logic [DWT_CW-1:0] dly_cnt_q, dly_cnt_d;
	logic [5:0] pre_q, pre_d;
	logic blank_q, blank_d, dly_act_q, dly_act_d, dev_q, dev_d;
	logic cap_a_q, cap_a_d, cap_b_q, cap_b_d;
	logic evp_a_q, evp_a_d, evp_b_q, evp_b_d;
	logic oa_q, oa_d, ob_q, ob_d;
	logic wr_go, rd_go, cycle_end, wr_ok;
	logic fault_a, fault_b, ev_a_gated, dly_trig;
	logic [5:0] presc_max;

	assign wr_go = aw_have_q && w_have_q && !bvalid_q;
	assign rd_go = s_axi_arvalid && !rvalid_q;

	// AXI write/read channel and register file next values
	always_comb begin
		aw_have_d = aw_have_q;
		aw_addr_d = aw_addr_q;
		w_have_d = w_have_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		bvalid_d = bvalid_q && !s_axi_bready;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q && !s_axi_rready;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		enable_d = enable_q;
		wave_scheme_sel_d = wave_scheme_sel_q;
		cmp_d = cmp_q;
		ev_a_d = ev_a_q;
		ev_b_d = ev_b_q;
		dly_d = dly_q;
		stop_eoc_d = stop_eoc_q;
		wr_ok = 1'b1;
		if (s_axi_awvalid && !aw_have_q) begin
			aw_have_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_have_q) begin
			w_have_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		// Self clearing once the counter takes the command
		if (stop_eoc_q && (cycle_end || !run_q)) begin
			stop_eoc_d = 1'b0;
		end
		if (wr_go) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			unique case (aw_addr_q)
				DWT_OFS_CTRL: begin
					if (w_strb_q[0]) begin
						enable_d = w_data_q[DWT_B_ENABLE];
						// Scheme is static: only while stopped
						if (!run_q) begin
							wave_scheme_sel_d = dwt_scheme_e'(w_data_q[DWT_B_SCHEME +: 2]);
						end
					end
				end
				DWT_OFS_CMD: begin
					if (w_strb_q[0] && w_data_q[DWT_B_STOP_EOC] && run_q) begin
						stop_eoc_d = 1'b1;
					end
				end
				DWT_OFS_CMP_SET_A: cmp_d.set_a = w_data_q[DWT_CW-1:0];
				DWT_OFS_CMP_CLR_A: cmp_d.clr_a = w_data_q[DWT_CW-1:0];
				DWT_OFS_CMP_SET_B: cmp_d.set_b = w_data_q[DWT_CW-1:0];
				DWT_OFS_CMP_CLR_B: cmp_d.clr_b = w_data_q[DWT_CW-1:0];
				DWT_OFS_EVCTRL: begin
					ev_a_d = {w_data_q[DWT_B_EV_EN], w_data_q[DWT_B_EV_ACTION],
						w_data_q[DWT_B_EV_ASYNC], w_data_q[DWT_B_FMODE +: 4]};
					ev_b_d = {w_data_q[DWT_EV_STRIDE + DWT_B_EV_EN],
						w_data_q[DWT_EV_STRIDE + DWT_B_EV_ACTION],
						w_data_q[DWT_EV_STRIDE + DWT_B_EV_ASYNC],
						w_data_q[DWT_EV_STRIDE + DWT_B_FMODE +: 4]};
				end
				DWT_OFS_DELAY: begin
					dly_d = {w_data_q[DWT_B_DSEL +: 2], w_data_q[DWT_B_DTRIG +: 2],
						w_data_q[DWT_B_DPRESC +: 2], w_data_q[DWT_B_DVAL +: DWT_CW]};
				end
				DWT_OFS_STATUS, DWT_OFS_COUNT: wr_ok = 1'b1;
				default: wr_ok = 1'b0;
			endcase
			bresp_d = wr_ok ? DWT_RESP_OKAY : DWT_RESP_SLVERR;
		end
		if (rd_go) begin
			rvalid_d = 1'b1;
			rresp_d = DWT_RESP_OKAY;
			rdata_d = '0;
			unique case (s_axi_araddr)
				DWT_OFS_CTRL: begin
					rdata_d[DWT_B_ENABLE] = enable_q;
					rdata_d[DWT_B_SCHEME +: 2] = wave_scheme_sel_q;
				end
				DWT_OFS_CMD: rdata_d[DWT_B_STOP_EOC] = stop_eoc_q;
				DWT_OFS_STATUS: begin
					rdata_d[DWT_B_EN_RDY] = 1'b1;
					rdata_d[DWT_B_CMD_RDY] = !stop_eoc_q;
					rdata_d[DWT_B_RUNNING] = run_q;
					rdata_d[DWT_B_OUT_A] = oa_q;
					rdata_d[DWT_B_OUT_B] = ob_q;
				end
				DWT_OFS_CMP_SET_A: rdata_d[DWT_CW-1:0] = cmp_q.set_a;
				DWT_OFS_CMP_CLR_A: rdata_d[DWT_CW-1:0] = cmp_q.clr_a;
				DWT_OFS_CMP_SET_B: rdata_d[DWT_CW-1:0] = cmp_q.set_b;
				DWT_OFS_CMP_CLR_B: rdata_d[DWT_CW-1:0] = cmp_q.clr_b;
				DWT_OFS_EVCTRL: begin
					rdata_d[DWT_B_FMODE +: 4] = ev_a_q.fmode;
					rdata_d[DWT_B_EV_EN] = ev_a_q.en;
					rdata_d[DWT_B_EV_ACTION] = ev_a_q.action;
					rdata_d[DWT_B_EV_ASYNC] = ev_a_q.async_det;
					rdata_d[DWT_EV_STRIDE + DWT_B_FMODE +: 4] = ev_b_q.fmode;
					rdata_d[DWT_EV_STRIDE + DWT_B_EV_EN] = ev_b_q.en;
					rdata_d[DWT_EV_STRIDE + DWT_B_EV_ACTION] = ev_b_q.action;
					rdata_d[DWT_EV_STRIDE + DWT_B_EV_ASYNC] = ev_b_q.async_det;
				end
				DWT_OFS_DELAY: begin
					rdata_d[DWT_B_DSEL +: 2] = dly_q.sel;
					rdata_d[DWT_B_DTRIG +: 2] = dly_q.trig;
					rdata_d[DWT_B_DPRESC +: 2] = dly_q.presc;
					rdata_d[DWT_B_DVAL +: DWT_CW] = dly_q.value;
				end
				DWT_OFS_COUNT: rdata_d[DWT_CW-1:0] = cnt_q;
				default: rresp_d = DWT_RESP_SLVERR;
			endcase
		end
		// Auto stop at cycle end clears the enable bit
		if (run_q && (cycle_end && stop_eoc_q)) begin
			enable_d = 1'b0;
		end
	end

	// Input fault detection: enabled, mode not zero; blanking on A only
	assign ev_a_gated = event_in_a && !blank_q;
	assign fault_a = ev_a_q.en && (ev_a_q.fmode != DWT_FMODE_NONE) && ev_a_gated;
	assign fault_b = ev_b_q.en && (ev_b_q.fmode != DWT_FMODE_NONE) && event_in_b;

	// End of cycle per scheme
	always_comb begin
		unique case (wave_scheme_sel_q)
			DWT_ONE_RAMP: cycle_end = (cnt_q == cmp_q.clr_b);
			// Either B state ends at clear-B, even when set-B is never reached
			DWT_TWO_RAMP: cycle_end = (state_q == DWT_DEAD_TIME_B || state_q == DWT_ON_TIME_B)
				&& (cnt_q == cmp_q.clr_b);
			DWT_FOUR_RAMP: cycle_end = (state_q == DWT_ON_TIME_B) && (cnt_q == cmp_q.clr_b);
			DWT_DUAL_SLOPE: cycle_end = !down_q && (cnt_q == cmp_q.clr_b);
		endcase
	end

	// Counter, state and raw waveform next values
	always_comb begin
		run_d = run_q;
		cnt_d = cnt_q;
		down_d = down_q;
		state_d = state_q;
		out_a_d = out_a_q;
		out_b_d = out_b_q;
		if (!run_q) begin
			out_a_d = 1'b0;
			out_b_d = 1'b0;
			if (enable_q) begin
				run_d = 1'b1;
				state_d = DWT_DEAD_TIME_A;
				// Dual slope starts at top counting down, outputs low
				cnt_d = (wave_scheme_sel_q == DWT_DUAL_SLOPE) ? cmp_q.clr_b : DWT_CNT_ZERO;
				down_d = (wave_scheme_sel_q == DWT_DUAL_SLOPE);
			end
		end else if (!enable_q) begin
			run_d = 1'b0;
			out_a_d = 1'b0;
			out_b_d = 1'b0;
		end else begin
			unique case (wave_scheme_sel_q)
				DWT_ONE_RAMP: begin
					cnt_d = cnt_q + DWT_CNT_ONE;
					if (cnt_q == cmp_q.clr_b) begin
						cnt_d = DWT_CNT_ZERO;
						out_a_d = 1'b0;
						out_b_d = 1'b0;
						state_d = DWT_DEAD_TIME_A;
					end else begin
						// Clear beats set only when clear is not the earlier match
						if (cnt_q == cmp_q.set_a) begin
							out_a_d = 1'b1;
							state_d = DWT_ON_TIME_A;
						end
						if (cnt_q == cmp_q.clr_a && cmp_q.clr_a >= cmp_q.set_a) begin
							out_a_d = 1'b0;
							state_d = DWT_DEAD_TIME_B;
						end
						if (cnt_q == cmp_q.set_b) begin
							out_b_d = 1'b1;
							state_d = DWT_ON_TIME_B;
						end
					end
				end
				DWT_TWO_RAMP: begin
					cnt_d = cnt_q + DWT_CNT_ONE;
					if (state_q == DWT_DEAD_TIME_A || state_q == DWT_ON_TIME_A) begin
						if (cnt_q == cmp_q.clr_a) begin
							cnt_d = DWT_CNT_ZERO;
							out_a_d = 1'b0;
							state_d = DWT_DEAD_TIME_B;
						end else if (cnt_q == cmp_q.set_a) begin
							out_a_d = 1'b1;
							state_d = DWT_ON_TIME_A;
						end
					end else if (cnt_q == cmp_q.clr_b) begin
						cnt_d = DWT_CNT_ZERO;
						out_b_d = 1'b0;
						state_d = DWT_DEAD_TIME_A;
					end else if (cnt_q == cmp_q.set_b) begin
						out_b_d = 1'b1;
						state_d = DWT_ON_TIME_B;
					end
				end
				DWT_FOUR_RAMP: begin
					cnt_d = cnt_q + DWT_CNT_ONE;
					unique case (state_q)
						DWT_DEAD_TIME_A: if (cnt_q == cmp_q.set_a) begin
							cnt_d = DWT_CNT_ZERO;
							out_a_d = 1'b1;
							state_d = DWT_ON_TIME_A;
						end
						DWT_ON_TIME_A: if (cnt_q == cmp_q.clr_a) begin
							cnt_d = DWT_CNT_ZERO;
							out_a_d = 1'b0;
							state_d = DWT_DEAD_TIME_B;
						end
						DWT_DEAD_TIME_B: if (cnt_q == cmp_q.set_b) begin
							cnt_d = DWT_CNT_ZERO;
							out_b_d = 1'b1;
							state_d = DWT_ON_TIME_B;
						end
						DWT_ON_TIME_B: if (cnt_q == cmp_q.clr_b) begin
							cnt_d = DWT_CNT_ZERO;
							out_b_d = 1'b0;
							state_d = DWT_DEAD_TIME_A;
						end
					endcase
				end
				DWT_DUAL_SLOPE: begin
					// Clear-A never consulted here
					if (down_q) begin
						cnt_d = cnt_q - DWT_CNT_ONE;
						if (cnt_q == DWT_CNT_ZERO) begin
							down_d = 1'b0;
							cnt_d = DWT_CNT_ZERO; // Zero held twice
						end
						if (cnt_q == cmp_q.set_a) out_a_d = 1'b1;
						if (cnt_q == cmp_q.set_b) out_b_d = 1'b0;
					end else begin
						cnt_d = cnt_q + DWT_CNT_ONE;
						if (cnt_q == cmp_q.clr_b) begin
							down_d = 1'b1;
							cnt_d = cnt_q; // Top held twice
						end
						if (cnt_q == cmp_q.set_a) out_a_d = 1'b0;
						if (cnt_q == cmp_q.set_b) out_b_d = 1'b1;
					end
					state_d = out_a_d ? DWT_ON_TIME_A : (out_b_d ? DWT_ON_TIME_B : DWT_DEAD_TIME_A);
				end
			endcase
			if (cycle_end && stop_eoc_q) begin
				run_d = 1'b0;
			end
		end
	end

	// Fault pipeline, delay unit and output override
	assign presc_max = 6'((7'h01 << {dly_q.presc, 1'b0}) - 7'h01);
	assign dly_trig = (dly_q.trig[0] ? out_a_q : out_b_q) != (dly_q.trig[0] ? out_a_d : out_b_d);
	always_comb begin
		pipe_a_d = {pipe_a_q[0], fault_a};
		pipe_b_d = {pipe_b_q[0], fault_b};
		pre_d = pre_q;
		dly_cnt_d = dly_cnt_q;
		dly_act_d = dly_act_q;
		dev_d = 1'b0;
		// Single delay unit serves blanking or output event
		if (dly_q.sel == DWT_DSEL_OFF) begin
			dly_act_d = 1'b0;
		end else if (dly_trig && run_q) begin
			dly_act_d = 1'b1;
			dly_cnt_d = DWT_CNT_ZERO;
			pre_d = '0;
		end else if (dly_act_q) begin
			pre_d = pre_q + 6'h01;
			if (pre_q == presc_max) begin
				pre_d = '0;
				dly_cnt_d = dly_cnt_q + DWT_CNT_ONE;
				if (dly_cnt_q + DWT_CNT_ONE >= dly_q.value) begin
					dly_act_d = 1'b0;
					dev_d = (dly_q.sel == DWT_DSEL_EVOUT);
				end
			end
		end
		blank_d = dly_act_d && (dly_q.sel == DWT_DSEL_BLANK);
		// Capture on the raw input's rising edge, whatever the fault mode
		evp_a_d = event_in_a;
		evp_b_d = event_in_b;
		cap_a_d = ev_a_q.en && ev_a_q.action && event_in_a && !evp_a_q;
		cap_b_d = ev_b_q.en && ev_b_q.action && event_in_b && !evp_b_q;
		// Async path overrides at once; sync after two stages
		oa_d = out_a_d && !(ev_a_q.async_det ? fault_a : pipe_a_q[1])
			&& !(ev_b_q.async_det ? fault_b : pipe_b_q[1]);
		ob_d = out_b_d && !(ev_a_q.async_det ? fault_a : pipe_a_q[1])
			&& !(ev_b_q.async_det ? fault_b : pipe_b_q[1]);
	end

	// All state registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
			bvalid_q <= 1'b0;
			rvalid_q <= 1'b0;
			bresp_q <= DWT_RESP_OKAY;
			rresp_q <= DWT_RESP_OKAY;
			rdata_q <= '0;
			enable_q <= 1'b0;
			wave_scheme_sel_q <= DWT_ONE_RAMP;
			cmp_q <= '0;
			ev_a_q <= '0;
			ev_b_q <= '0;
			dly_q <= '0;
			stop_eoc_q <= 1'b0;
			run_q <= 1'b0;
			down_q <= 1'b0;
			cnt_q <= DWT_CNT_ZERO;
			state_q <= DWT_DEAD_TIME_A;
			out_a_q <= 1'b0;
			out_b_q <= 1'b0;
			pipe_a_q <= '0;
			pipe_b_q <= '0;
			dly_cnt_q <= DWT_CNT_ZERO;
			pre_q <= '0;
			blank_q <= 1'b0;
			dly_act_q <= 1'b0;
			dev_q <= 1'b0;
			cap_a_q <= 1'b0;
			cap_b_q <= 1'b0;
			evp_a_q <= 1'b0;
			evp_b_q <= 1'b0;
			oa_q <= 1'b0;
			ob_q <= 1'b0;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			aw_addr_q <= aw_addr_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			bvalid_q <= bvalid_d;
			rvalid_q <= rvalid_d;
			bresp_q <= bresp_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			enable_q <= enable_d;
			wave_scheme_sel_q <= wave_scheme_sel_d;
			cmp_q <= cmp_d;
			ev_a_q <= ev_a_d;
			ev_b_q <= ev_b_d;
			dly_q <= dly_d;
			stop_eoc_q <= stop_eoc_d;
			run_q <= run_d;
			down_q <= down_d;
			cnt_q <= cnt_d;
			state_q <= state_d;
			out_a_q <= out_a_d;
			out_b_q <= out_b_d;
			pipe_a_q <= pipe_a_d;
			pipe_b_q <= pipe_b_d;
			dly_cnt_q <= dly_cnt_d;
			pre_q <= pre_d;
			blank_q <= blank_d;
			dly_act_q <= dly_act_d;
			dev_q <= dev_d;
			cap_a_q <= cap_a_d;
			cap_b_q <= cap_b_d;
			evp_a_q <= evp_a_d;
			evp_b_q <= evp_b_d;
			oa_q <= oa_d;
			ob_q <= ob_d;
		end
	end

	// Port drive from flip-flops
	assign s_axi_awready = !aw_have_q;
	assign s_axi_wready = !w_have_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign wave_out_a = oa_q;
	assign wave_out_b = ob_q;
	assign capture_a = cap_a_q;
	assign capture_b = cap_b_q;
	assign delay_event_out = dev_q;
endmodule

/* hw/dwt_pkg.sv */
// Package for the dead-time waveform timer: register map, fields, types.
package dwt_pkg;
	localparam int unsigned DWT_CW = 12;
	// Register byte offsets
	localparam logic [7:0] DWT_OFS_CTRL = 8'h00;
	localparam logic [7:0] DWT_OFS_CMD = 8'h04;
	localparam logic [7:0] DWT_OFS_STATUS = 8'h08;
	localparam logic [7:0] DWT_OFS_CMP_SET_A = 8'h0C;
	localparam logic [7:0] DWT_OFS_CMP_CLR_A = 8'h10;
	localparam logic [7:0] DWT_OFS_CMP_SET_B = 8'h14;
	localparam logic [7:0] DWT_OFS_CMP_CLR_B = 8'h18;
	localparam logic [7:0] DWT_OFS_EVCTRL = 8'h1C;
	localparam logic [7:0] DWT_OFS_DELAY = 8'h20;
	localparam logic [7:0] DWT_OFS_COUNT = 8'h24;
	// CTRL fields
	localparam int unsigned DWT_B_ENABLE = 0;
	localparam int unsigned DWT_B_SCHEME = 4;
	// CMD fields
	localparam int unsigned DWT_B_STOP_EOC = 0;
	// STATUS fields
	localparam int unsigned DWT_B_EN_RDY = 0;
	localparam int unsigned DWT_B_CMD_RDY = 1;
	localparam int unsigned DWT_B_RUNNING = 2;
	localparam int unsigned DWT_B_OUT_A = 3;
	localparam int unsigned DWT_B_OUT_B = 4;
	// EVCTRL fields: per input byte, A at 0, B at 8
	localparam int unsigned DWT_B_EV_EN = 0;
	localparam int unsigned DWT_B_EV_ACTION = 1;
	localparam int unsigned DWT_B_EV_ASYNC = 2;
	localparam int unsigned DWT_B_FMODE = 4;
	localparam int unsigned DWT_EV_STRIDE = 8;
	// DELAY fields
	localparam int unsigned DWT_B_DSEL = 0;
	localparam int unsigned DWT_B_DTRIG = 2;
	localparam int unsigned DWT_B_DPRESC = 4;
	localparam int unsigned DWT_B_DVAL = 8;
	localparam logic [1:0] DWT_DSEL_OFF = 2'h0;
	localparam logic [1:0] DWT_DSEL_BLANK = 2'h1;
	localparam logic [1:0] DWT_DSEL_EVOUT = 2'h2;
	localparam logic [1:0] DWT_RESP_OKAY = 2'h0;
	localparam logic [1:0] DWT_RESP_SLVERR = 2'h2;
	localparam logic [3:0] DWT_FMODE_NONE = 4'h0;
	localparam logic [DWT_CW-1:0] DWT_CNT_ZERO = 12'h000;
	localparam logic [DWT_CW-1:0] DWT_CNT_ONE = 12'h001;

	typedef enum logic [1:0] {
		DWT_ONE_RAMP = 2'h0,
		DWT_TWO_RAMP = 2'h1,
		DWT_FOUR_RAMP = 2'h2,
		DWT_DUAL_SLOPE = 2'h3
	} dwt_scheme_e;

	// Gray coded state sequence
	typedef enum logic [1:0] {
		DWT_DEAD_TIME_A = 2'b00,
		DWT_ON_TIME_A = 2'b01,
		DWT_DEAD_TIME_B = 2'b11,
		DWT_ON_TIME_B = 2'b10
	} dwt_state_e;

	typedef struct packed {
		logic [DWT_CW-1:0] set_a;
		logic [DWT_CW-1:0] clr_a;
		logic [DWT_CW-1:0] set_b;
		logic [DWT_CW-1:0] clr_b;
	} dwt_cmp_s;

	typedef struct packed {
		logic en;
		logic action;
		logic async_det;
		logic [3:0] fmode;
	} dwt_evcfg_s;

	typedef struct packed {
		logic [1:0] sel;
		logic [1:0] trig;
		logic [1:0] presc;
		logic [DWT_CW-1:0] value;
	} dwt_delay_s;
endpackage

/* tb/dwt_timer_properties.sv */
// Checker of bus handshakes and pulse outputs of the waveform timer.
`timescale 1ns/100ps
module dwt_timer_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic capture_a,
	input wire logic delay_event_out,
	input wire logic wave_out_a
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Write answer follows both halves
	write_answer_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped before taken");
	write_clear_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer not released");
	// Read answer and blocking
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	read_clear_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer not released");
	// Event pulses last one cycle
	capture_pulse_a: assert property (capture_a |=> !capture_a)
		else $error("capture pulse too long");
	delay_pulse_a: assert property ($rose(delay_event_out) |=> $fell(delay_event_out))
		else $error("delay event pulse too long");
	cover property (capture_a);
	cover property (delay_event_out);
	cover property ($rose(wave_out_a));
endmodule

bind dwt_timer dwt_timer_chk u_dwt_timer_chk (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .capture_a, .delay_event_out, .wave_out_a);

/* tb/dwt_gate_model.sv */
// Gate driver and event source model: fault lines and pulse timing.
`timescale 1ns/100ps
module dwt_gate_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wave_out_a,
	input wire logic wave_out_b,
	input wire logic req_a,
	input wire logic req_b,
	output logic event_in_a,
	output logic event_in_b,
	output int per_a,
	output int hi_a,
	output int hi_b
);
	int n, ca, cb;
	logic pa;
	// Fault lines follow requests; measure period and on times
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{event_in_a, event_in_b, pa} <= '0;
			{n, ca, cb, per_a, hi_a, hi_b} <= '0;
		end else begin
			event_in_a <= req_a;
			event_in_b <= req_b;
			pa <= wave_out_a;
			n <= (wave_out_a && !pa) ? 1 : n + 1;
			if (wave_out_a && !pa) per_a <= n;
			ca <= wave_out_a ? ca + 1 : 0;
			if (!wave_out_a && ca != 0) hi_a <= ca;
			cb <= wave_out_b ? cb + 1 : 0;
			if (!wave_out_b && cb != 0) hi_b <= cb;
		end
	end
endmodule

/* tb/test_dwt_timer.sv */
// Self-checking bench for the waveform timer: bus tasks and scheme tests.
`timescale 1ns/100ps
module test_dwt_timer;
	import dwt_pkg::*;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, req_a = 1'h0, req_b = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic event_in_a, event_in_b, wave_out_a, wave_out_b, capture_a, capture_b, delay_event_out;
	int per_a, hi_a, hi_b, hits, caps, dly_n;
	int err_count = 0;
	int samples_checked = 0;
	int fc [4] = '{32'h40, 32'h41, 32'h45, 32'h01};
	int fe [4] = '{1, 0, 0, 1};

	always #10 clk = ~clk;
	always @(posedge clk) dly_n += int'(delay_event_out === 1'h1);

	dwt_timer u_dwt_timer (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .event_in_a, .event_in_b, .wave_out_a,
		.wave_out_b, .capture_a, .capture_b, .delay_event_out);
	dwt_gate_model u_dwt_gate_model (.clk, .rst_n, .wave_out_a, .wave_out_b, .req_a, .req_b,
		.event_in_a, .event_in_b, .per_a, .hi_a, .hi_b);

	// Compare one result
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Bus write, both halves offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		bit t;
		t = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!t) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) begin
				t = 1;
				s_axi_bready <= 1'h0;
				chk("bresp", DWT_RESP_OKAY, s_axi_bresp);
			end
		end
	endtask

	// Bus read into d and r
	task automatic rd(input logic [7:0] a);
		bit t;
		t = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		while (!t) begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) begin
				t = 1;
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'h0;
			end
		end
	endtask

	// Run one scheme, measure period and on times, then stop it
	task automatic run(input logic [1:0] s, input int p, input int ha, input int hb);
		wr(DWT_OFS_CTRL, {26'h0, s, 4'h0});
		wr(DWT_OFS_CTRL, {26'h0, s, 4'h1});
		repeat (100) @(posedge clk);
		chk("period", p, per_a);
		chk("high a", ha, hi_a);
		chk("high b", hb, hi_b);
		wr(DWT_OFS_CTRL, {26'h0, s, 4'h0});
		repeat (3) @(posedge clk);
		chk("idle", 32'h0, {wave_out_a, wave_out_b});
		$display("test scheme %0d done", s);
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Tests take under 1000 cycles; allow ten times that
	initial begin
		#200us;
		err_count++;
		end_sim();
	end

	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'h1;
		rd(DWT_OFS_CTRL);
		chk("ctrl reset", 32'h0, d);
		rd(DWT_OFS_STATUS);
		chk("enable ready", 32'h1, d[DWT_B_EN_RDY]);
		rd(8'h40);
		chk("unmapped", DWT_RESP_SLVERR, r);
		$display("test reset done");
		wr(DWT_OFS_CMP_SET_A, 32'h2);
		wr(DWT_OFS_CMP_CLR_A, 32'h5);
		wr(DWT_OFS_CMP_SET_B, 32'h7);
		wr(DWT_OFS_CMP_CLR_B, 32'h9);
		wr(DWT_OFS_DELAY, 32'h302);
		run(DWT_ONE_RAMP, 10, 3, 2);
		run(DWT_TWO_RAMP, 16, 3, 2);
		run(DWT_FOUR_RAMP, 27, 6, 10);
		run(DWT_DUAL_SLOPE, 20, 5, 5);
		chk("delay events", 32'h1, dly_n != 0);
		wr(DWT_OFS_CTRL, 32'h1);
		wr(DWT_OFS_CMD, 32'h1);
		repeat (30) @(posedge clk);
		rd(DWT_OFS_STATUS);
		chk("running", 32'h0, d[DWT_B_RUNNING]);
		rd(DWT_OFS_CMD);
		chk("cmd clear", 32'h0, d);
		$display("test stop at end done");
		foreach (fc[i]) begin
			wr(DWT_OFS_EVCTRL, fc[i]);
			wr(DWT_OFS_CTRL, 32'h1);
			req_a <= 1'h1;
			repeat (5) @(posedge clk);
			hits = 0;
			repeat (20) @(posedge clk) hits += int'(wave_out_a | wave_out_b);
			chk("outputs live", fe[i], hits != 0);
			req_a <= 1'h0;
			wr(DWT_OFS_CTRL, 32'h0);
		end
		$display("test fault done");
		wr(DWT_OFS_EVCTRL, 32'h303);
		caps = 0;
		hits = 0;
		req_a <= 1'h1;
		req_b <= 1'h1;
		repeat (6) @(posedge clk) begin
			caps += int'(capture_a === 1'h1);
			hits += int'(capture_b === 1'h1);
		end
		chk("capture a", 32'h1, caps);
		chk("capture b", 32'h1, hits);
		req_a <= 1'h0;
		req_b <= 1'h0;
		$display("test capture done");
		end_sim();
	end
endmodule
